/* File: verilog/vfd_pkg.sv */
// Shared constants and types of the VLIW fetch and dispatch core.
// Assumes a single 200 MHz clock domain and same-clock program and data memories.
`default_nettype none
package vfd_pkg;
  localparam int SLOTS = 8;
  localparam int NREG = 16;
  localparam logic [31:0] RESET_PC = 32'h0000_0000;
  localparam logic [31:0] FPKT_BYTES = 32'h0000_0020;
  // Instruction field positions
  localparam int P_BIT = 0;
  localparam int AUX_BIT = 1;
  localparam int UNIT_LSB = 2;
  localparam int OP_LSB = 5;
  localparam int FP_BIT = 9;
  localparam int LOFF_LSB = 9;
  localparam int X_BIT = 10;
  localparam int CST_LSB = 11;
  localparam int SRC2_LSB = 16;
  localparam int SRC1_LSB = 20;
  localparam int DST_LSB = 24;
  localparam int Z_BIT = 28;
  localparam int CREG_LSB = 29;
  // Unit kinds within a side
  localparam logic [1:0] KIND_ALU = 2'h0;
  localparam logic [1:0] KIND_SBU = 2'h1;
  localparam logic [1:0] KIND_MUL = 2'h2;
  localparam logic [1:0] KIND_DAU = 2'h3;
  // Integer opcodes
  localparam logic [3:0] OP_ADD = 4'h0;
  localparam logic [3:0] OP_SUB = 4'h1;
  localparam logic [3:0] OP_AND = 4'h2;
  localparam logic [3:0] OP_OR = 4'h3;
  localparam logic [3:0] OP_XOR = 4'h4;
  localparam logic [3:0] OP_MVK = 4'h5;
  localparam logic [3:0] OP_CMPEQ = 4'h6;
  localparam logic [3:0] OP_SHL = 4'h7;
  localparam logic [3:0] OP_SHR = 4'h8;
  localparam logic [3:0] OP_BRANCH = 4'h9;
  localparam logic [3:0] OP_LDD = 4'hA;
  // Floating-point opcodes
  localparam logic [3:0] FOP_MOV = 4'h0;
  localparam logic [3:0] FOP_NEG = 4'h1;
  localparam logic [3:0] FOP_ABS = 4'h2;
  // Data unit access sizes, op[2:1]; op[3] store, op[0] unsigned
  localparam logic [1:0] SZ_B = 2'h0;
  localparam logic [1:0] SZ_H = 2'h1;
  localparam logic [1:0] SZ_W = 2'h2;
  localparam logic [1:0] SZ_L = 2'h3;
  localparam logic [3:0] LONG_BASE = 4'hE;
  localparam int CIRC_BITS = 8;
  localparam logic [7:0] DW_BE = 8'hFF;
  // Condition register select
  localparam logic [2:0] CREG_NONE = 3'h0;
  localparam logic [2:0] CREG_B0 = 3'h1;
  localparam logic [2:0] CREG_B1 = 3'h2;
  localparam logic [2:0] CREG_B2 = 3'h3;
  localparam logic [2:0] CREG_A1 = 3'h4;
  localparam logic [2:0] CREG_A2 = 3'h5;

  typedef enum logic [2:0] {
    arithmetic_logic_unit_a, shift_branch_unit_a, multiply_unit_a, data_address_unit_a,
    arithmetic_logic_unit_b, shift_branch_unit_b, multiply_unit_b, data_address_unit_b
  } vfd_unit_t;

  typedef logic [7:0][31:0] vfd_fpkt_t;
  typedef logic [1:0][15:0][31:0] vfd_rf_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [7:0] be;
    logic [63:0] wdata;
  } vfd_mreq_t;

  typedef struct packed {
    logic v;
    logic side;
    logic [3:0] dst;
    logic [1:0] sz;
    logic uns;
    logic dbl;
    logic [2:0] lane;
  } vfd_ld_t;
endpackage
`default_nettype wire

/* File: verilog/vfd_unit.sv */
// One functional unit's result logic, purely combinational.
// Assumes operands are read from the register files by the caller.
`default_nettype none
module vfd_unit (
  input wire logic [1:0] kind,
  input wire logic [31:0] ins,
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  output logic [31:0] res,
  output logic wr,
  output logic br,
  output logic bad
);
  always_comb begin
    logic [3:0] op;
    logic [31:0] k;
    op = ins[vfd_pkg::OP_LSB +: 4];
    k = {{27{ins[vfd_pkg::CST_LSB + 4]}}, ins[vfd_pkg::CST_LSB +: 5]};
    res = '0;
    wr = 1'b1;
    br = 1'b0;
    bad = 1'b0;
    if (ins[vfd_pkg::FP_BIT]) begin
      bad = (kind == vfd_pkg::KIND_SBU);
      case (op)
        vfd_pkg::FOP_MOV: res = b;
        vfd_pkg::FOP_NEG: res = {~b[31], b[30:0]};
        vfd_pkg::FOP_ABS: res = {1'b0, b[30:0]};
        default: bad = 1'b1;
      endcase
    end else if (kind == vfd_pkg::KIND_MUL) begin
      res = 32'(a * b);
    end else if (kind == vfd_pkg::KIND_DAU) begin
      wr = 1'b0;
    end else begin
      case (op)
        vfd_pkg::OP_ADD: res = a + b;
        vfd_pkg::OP_SUB: res = a - b;
        vfd_pkg::OP_AND: res = a & b;
        vfd_pkg::OP_OR: res = a | b;
        vfd_pkg::OP_XOR: res = a ^ b;
        vfd_pkg::OP_MVK: res = k;
        vfd_pkg::OP_CMPEQ: res = {31'h0, a == b};
        vfd_pkg::OP_SHL: res = a << b[4:0];
        vfd_pkg::OP_SHR: res = a >> b[4:0];
        vfd_pkg::OP_BRANCH: begin
          res = b;
          wr = 1'b0;
          br = 1'b1;
        end
        vfd_pkg::OP_LDD: begin
          wr = 1'b0;
          bad = (kind != vfd_pkg::KIND_SBU);
        end
        default: bad = 1'b1;
      endcase
    end
    if (bad) begin
      wr = 1'b0;
      br = 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/vfd_core.sv */
// Fetch, execute-packet dispatch and two-sided datapath of the VLIW core.
// Assumes program memory answers a fetch request with fetch_vld after any number of cycles and data
// memory returns read data in the cycle after a request is shown.
`default_nettype none
// Function
// - Fetch whole 256-bit packets of eight slots
// - Set low bit chains next slot in
// - Clear low bit ends the execute packet
// - Up to eight instructions drive units together
// - One to eight execute packets per fetch
// - One execute packet issued each clock in dispatch
// - Next fetch only after last packet issued or a taken branch
// - Two files of sixteen 32-bit registers
// - Four named units on each side
// - Same-side units all read and write together
// - One cross read or write per side
// - Floating point not on shift-branch units
// - Shift-branch units do 64-bit double loads
// - Data units load or store either side
// - Linear or circular addressing, 5/15-bit offsets
// - Every instruction conditional on chosen registers
// - Multipliers multiply; arithmetic and shift-branch units compute and branch
// - Byte, half-word and word memory access
module vfd_core (
  input wire logic mclk,
  input wire logic arst_n,
  output logic fetch_req,
  output logic [31:0] fetch_addr,
  input wire logic fetch_vld,
  input wire vfd_pkg::vfd_fpkt_t fetch_data,
  output logic [7:0] unit_valid,
  output logic [7:0][31:0] unit_instr,
  output vfd_pkg::vfd_mreq_t [3:0] mem_out,
  input wire logic [3:0][63:0] mem_rdata,
  output logic pkt_issue,
  output logic route_err,
  output logic illegal_err,
  input wire logic dbg_side,
  input wire logic [3:0] dbg_idx,
  output logic [31:0] dbg_data
);
  typedef enum logic {st_fetch, st_disp} vfd_st_t;

  typedef struct packed {
    vfd_st_t st;
    logic [31:0] pc;
    logic [2:0] idx;
    vfd_pkg::vfd_fpkt_t pkt;
    logic [7:0] dv;
    logic [7:0][31:0] di;
    vfd_pkg::vfd_rf_t rf;
    vfd_pkg::vfd_mreq_t [3:0] mq;
    vfd_pkg::vfd_ld_t [3:0] ld;
    vfd_pkg::vfd_ld_t [3:0] ldr;
    logic iss;
    logic conf;
    logic ill;
    logic [31:0] dbg;
  } vfd_state_t;

  vfd_state_t q, d;
  logic [7:0] sv;
  logic [7:0][31:0] si;
  logic [2:0] last;
  logic [3:0] cnt;
  logic rc;
  logic [7:0] xg, xblk, cp, uwr, ubr, ubad;
  logic [7:0][31:0] ua, ub, ures;
  logic brk;
  logic [31:0] tgt;

  function automatic logic cond_ok(input logic [31:0] ins, input vfd_pkg::vfd_rf_t rf);
    logic [31:0] v;
    logic ok;
    v = '0;
    ok = 1'b1;
    case (ins[vfd_pkg::CREG_LSB +: 3])
      vfd_pkg::CREG_NONE: ok = 1'b1;
      vfd_pkg::CREG_B0: v = rf[1][0];
      vfd_pkg::CREG_B1: v = rf[1][1];
      vfd_pkg::CREG_B2: v = rf[1][2];
      vfd_pkg::CREG_A1: v = rf[0][1];
      vfd_pkg::CREG_A2: v = rf[0][2];
      default: ok = 1'b0;
    endcase
    if (ok && ins[vfd_pkg::CREG_LSB +: 3] != vfd_pkg::CREG_NONE) begin
      ok = ins[vfd_pkg::Z_BIT] ? (v == 32'h0) : (v != 32'h0);
    end
    return ok;
  endfunction

  function automatic logic [31:0] ea(input logic [31:0] base, input logic [31:0] off,
                                     input logic circ);
    logic [31:0] sum;
    sum = base + off;
    // Circular mode wraps inside an aligned block
    return circ ? {base[31:vfd_pkg::CIRC_BITS], sum[vfd_pkg::CIRC_BITS-1:0]} : sum;
  endfunction

  // Execute packet selection from the held fetch packet
  always_comb begin
    logic live;
    live = 1'b0;
    last = 3'h7;
    cnt = 4'h0;
    rc = 1'b0;
    sv = '0;
    si = '0;
    for (int j = 0; j < vfd_pkg::SLOTS; j++) begin
      logic [2:0] un;
      un = q.pkt[j][vfd_pkg::UNIT_LSB +: 3];
      if (3'(j) == q.idx) begin
        live = 1'b1;
      end
      if (live) begin
        cnt = cnt + 4'h1;
        if (sv[un]) begin
          rc = 1'b1;
        end else begin
          sv[un] = 1'b1;
          si[un] = q.pkt[j];
        end
        if (!q.pkt[j][vfd_pkg::P_BIT]) begin
          last = 3'(j);
          live = 1'b0;
        end
      end
    end
  end

  // Operand fetch and cross path arbitration
  always_comb begin
    logic [1:0] xb;
    xb = 2'h0;
    xg = '0;
    xblk = '0;
    for (int u = 0; u < vfd_pkg::SLOTS; u++) begin
      logic s;
      logic xu;
      logic [31:0] ins;
      s = (u >= 4);
      ins = q.di[u];
      xu = q.dv[u] && ((2'(u) == vfd_pkg::KIND_DAU) ? ins[vfd_pkg::AUX_BIT] : ins[vfd_pkg::X_BIT]);
      if (xu && !xb[s]) begin
        xb[s] = 1'b1;
        xg[u] = 1'b1;
      end else if (xu) begin
        xblk[u] = 1'b1;
      end
      ua[u] = q.rf[s][ins[vfd_pkg::SRC1_LSB +: 4]];
      ub[u] = (xg[u] && 2'(u) != vfd_pkg::KIND_DAU) ? q.rf[!s][ins[vfd_pkg::SRC2_LSB +: 4]]
                                                     : q.rf[s][ins[vfd_pkg::SRC2_LSB +: 4]];
      cp[u] = cond_ok(ins, q.rf);
    end
  end

  // Eight units, side A then side B
  for (genvar g = 0; g < vfd_pkg::SLOTS; g++) begin : g_unit
    vfd_unit u_unit (
      .kind(2'(g % 4)),
      .ins(q.di[g]),
      .a(ua[g]),
      .b(ub[g]),
      .res(ures[g]),
      .wr(uwr[g]),
      .br(ubr[g]),
      .bad(ubad[g])
    );
  end

  always_comb begin
    d = q;
    d.dv = '0;
    d.iss = 1'b0;
    d.conf = 1'b0;
    d.ill = 1'b0;
    d.mq = '0;
    d.ld = '0;
    d.ldr = q.ld;
    brk = 1'b0;
    tgt = '0;
    d.dbg = q.rf[dbg_side][dbg_idx];
    for (int u = 0; u < vfd_pkg::SLOTS; u++) begin
      logic s, ts, go;
      logic [31:0] ins, ad, sd;
      logic [1:0] sz;
      logic [3:0] op, dst;
      int p;
      s = (u >= 4);
      ins = q.di[u];
      op = ins[vfd_pkg::OP_LSB +: 4];
      dst = ins[vfd_pkg::DST_LSB +: 4];
      sz = op[2:1];
      ts = s ^ ins[vfd_pkg::AUX_BIT];
      go = q.dv[u] && cp[u] && !xblk[u] && !ubad[u];
      ad = '0;
      sd = q.rf[ts][dst];
      p = s ? 1 : 0;
      if (q.dv[u] && ubad[u]) begin
        d.ill = 1'b1;
      end
      if (q.dv[u] && xblk[u]) begin
        d.conf = 1'b1;
      end
      if (go && uwr[u]) begin
        d.rf[s][dst] = ures[u];
      end
      if (go && ubr[u] && !brk) begin
        brk = 1'b1;
        tgt = ures[u];
      end
      if (go && 2'(u) == vfd_pkg::KIND_DAU && !ins[vfd_pkg::FP_BIT]) begin
        if (sz == vfd_pkg::SZ_L) begin
          ad = q.rf[s][vfd_pkg::LONG_BASE] + {15'h0, ins[vfd_pkg::LOFF_LSB +: 15], 2'h0};
          sz = vfd_pkg::SZ_W;
        end else begin
          ad = ea(ua[u], {27'h0, ins[vfd_pkg::CST_LSB +: 5]} << sz, ins[vfd_pkg::X_BIT]);
        end
        d.mq[p].req = 1'b1;
        d.mq[p].addr = ad;
        case (sz)
          vfd_pkg::SZ_B: begin
            d.mq[p].be = 8'h01 << ad[2:0];
            d.mq[p].wdata = {8{sd[7:0]}};
          end
          vfd_pkg::SZ_H: begin
            d.mq[p].be = 8'h03 << ad[2:0];
            d.mq[p].wdata = {4{sd[15:0]}};
          end
          default: begin
            d.mq[p].be = 8'h0F << ad[2:0];
            d.mq[p].wdata = {2{sd}};
          end
        endcase
        if (op[3]) begin
          d.mq[p].we = 1'b1;
        end else begin
          d.ld[p] = '{v: 1'b1, side: ts, dst: dst, sz: sz, uns: op[0], dbl: 1'b0,
                      lane: ad[2:0]};
        end
      end
      if (go && 2'(u) == vfd_pkg::KIND_SBU && !ins[vfd_pkg::FP_BIT] && op == vfd_pkg::OP_LDD) begin
        ad = ua[u] + {24'h0, ins[vfd_pkg::CST_LSB +: 5], 3'h0};
        d.mq[p + 2].req = 1'b1;
        d.mq[p + 2].addr = {ad[31:3], 3'h0};
        d.mq[p + 2].be = vfd_pkg::DW_BE;
        d.ld[p + 2] = '{v: 1'b1, side: s, dst: dst, sz: vfd_pkg::SZ_W, uns: 1'b0, dbl: 1'b1,
                        lane: 3'h0};
      end
    end
    // Load returns land after unit results
    for (int p = 0; p < 4; p++) begin
      logic [63:0] sh;
      vfd_pkg::vfd_ld_t l;
      l = q.ldr[p];
      sh = mem_rdata[p] >> {l.lane, 3'h0};
      if (l.v && l.dbl) begin
        d.rf[l.side][{l.dst[3:1], 1'b0}] = mem_rdata[p][31:0];
        d.rf[l.side][{l.dst[3:1], 1'b1}] = mem_rdata[p][63:32];
      end else if (l.v) begin
        case (l.sz)
          vfd_pkg::SZ_B: d.rf[l.side][l.dst] = {{24{!l.uns && sh[7]}}, sh[7:0]};
          vfd_pkg::SZ_H: d.rf[l.side][l.dst] = {{16{!l.uns && sh[15]}}, sh[15:0]};
          default: d.rf[l.side][l.dst] = sh[31:0];
        endcase
      end
    end
    case (q.st)
      st_fetch: begin
        if (fetch_vld) begin
          d.pkt = fetch_data;
          d.st = st_disp;
        end
      end
      st_disp: begin
        d.dv = sv;
        d.di = si;
        d.iss = 1'b1;
        d.conf = d.conf | rc;
        if (last == 3'h7) begin
          d.st = st_fetch;
          d.pc = q.pc + vfd_pkg::FPKT_BYTES;
          d.idx = 3'h0;
        end else begin
          d.idx = 3'(last + 3'h1);
        end
      end
      default: d.st = st_fetch;
    endcase
    if (brk) begin
      d.st = st_fetch;
      d.dv = '0;
      d.iss = 1'b0;
      d.pc = {tgt[31:5], 5'h0};
      d.idx = tgt[4:2];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '{st: st_fetch, pc: vfd_pkg::RESET_PC, default: '0};
    end else begin
      q <= d;
    end
  end

  assign fetch_req = (q.st == st_fetch);
  assign fetch_addr = q.pc;
  assign unit_valid = q.dv;
  assign unit_instr = q.di;
  assign mem_out = q.mq;
  assign pkt_issue = q.iss;
  assign route_err = q.conf;
  assign illegal_err = q.ill;
  assign dbg_data = q.dbg;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  sequence s_pkt_in;
    fetch_req && fetch_vld && !brk;
  endsequence
  sequence s_disp_issue;
    (q.st == st_disp) ##1 pkt_issue;
  endsequence

  a_fetch_to_issue: assert property (s_pkt_in |=> s_disp_issue)
    else $error("packet fetched but not issued");
  a_issue_each_clk: assert property ((q.st == st_disp && !brk) |=> pkt_issue)
    else $error("dispatch cycle without issue");
  a_chain_count: assert property ((q.st == st_disp && !brk && !rc)
    |=> $countones(unit_valid) == $past(cnt))
    else $error("issued count differs from chain length");
  a_chain_break: assert property ((q.st == st_disp && !brk && last != 3'h7)
    |=> !fetch_req && q.idx == 3'($past(last) + 3'h1))
    else $error("next packet start wrong");
  a_fetch_last: assert property ((q.st == st_disp && !brk && last == 3'h7)
    |=> fetch_req && fetch_addr == 32'($past(q.pc) + vfd_pkg::FPKT_BYTES))
    else $error("fetch not requested after last packet");
  a_cross_one: assert property ($countones(xg[3:0]) <= 1 && $countones(xg[7:4]) <= 1)
    else $error("more than one cross path use per side");
  a_cond_quiet: assert property ((unit_valid[3] && !cp[3]) |=> !mem_out[0].req)
    else $error("false condition made an access");
  a_sbu_no_fp: assert property ((unit_valid[1] && unit_instr[1][9]) |=> illegal_err)
    else $error("float on shift-branch unit not refused");
  a_dword_load: assert property ((unit_valid[5] && cp[5] && !xblk[5] && !unit_instr[5][9]
    && unit_instr[5][8:5] == 4'hA) |=> mem_out[3].req && mem_out[3].be == 8'hFF
    && !mem_out[3].we)
    else $error("double load not issued");
  a_byte_store: assert property ((mem_out[1].req && mem_out[1].we && $countones(mem_out[1].be) == 1)
    |-> $past(unit_instr[7][7:6]) == 2'h0)
    else $error("single byte lane without byte store");
endmodule
`default_nettype wire

/* File: sim/vfd_pmem.sv */
// Program memory model: four fetch packets, answers fetch requests after lat cycles.
// Assumes the bench loads mem and drives lat; outputs change at the falling edge.
`default_nettype none
module vfd_pmem (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic fetch_req,
  input wire logic [31:0] fetch_addr,
  input wire logic [3:0] lat,
  output var logic fetch_vld,
  output vfd_pkg::vfd_fpkt_t fetch_data
);
  timeunit 1ns;
  timeprecision 100ps;
  vfd_pkg::vfd_fpkt_t mem [0:3];
  logic [3:0] cnt_q;
  // Held until the taken edge; junk that toggles while idle
  always @(negedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fetch_vld <= 1'b0;
      fetch_data <= '0;
      cnt_q <= 4'h0;
    end else if (fetch_req && cnt_q >= lat) begin
      fetch_vld <= 1'b1;
      fetch_data <= mem[fetch_addr[6:5]];
    end else begin
      fetch_vld <= 1'b0;
      fetch_data <= ~fetch_data;
      cnt_q <= fetch_req ? cnt_q + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

/* File: sim/test_vfd_core.sv */
// Self-checking bench of the fetch and dispatch core.
// Assumes vfd_pmem as program memory; inputs change at the falling edge.
`default_nettype none
module test_vfd_core;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk;
  logic arst_n;
  logic fetch_req;
  logic [31:0] fetch_addr;
  logic fetch_vld;
  vfd_pkg::vfd_fpkt_t fetch_data;
  logic [7:0] unit_valid;
  logic [7:0][31:0] unit_instr;
  vfd_pkg::vfd_mreq_t [3:0] mem_out;
  logic [3:0][63:0] mem_rdata;
  logic pkt_issue;
  logic route_err;
  logic illegal_err;
  logic dbg_side;
  logic [3:0] dbg_idx;
  logic [31:0] dbg_data;
  logic [3:0] lat;
  int mismatches;
  int compares;

  vfd_core vfd_core_inst (.mclk(mclk), .arst_n(arst_n), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_vld(fetch_vld), .fetch_data(fetch_data),
    .unit_valid(unit_valid), .unit_instr(unit_instr), .mem_out(mem_out),
    .mem_rdata(mem_rdata), .pkt_issue(pkt_issue), .route_err(route_err),
    .illegal_err(illegal_err), .dbg_side(dbg_side), .dbg_idx(dbg_idx),
    .dbg_data(dbg_data));
  vfd_pmem vfd_pmem_inst (.mclk(mclk), .arst_n(arst_n), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .lat(lat), .fetch_vld(fetch_vld), .fetch_data(fetch_data));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  function automatic logic [31:0] ins(logic [2:0] creg, logic z, logic [3:0] dst,
      logic [3:0] s1, logic [3:0] s2, logic [4:0] cst, logic fp, logic [3:0] op,
      logic [2:0] u, logic p);
    ins = {creg, z, dst, s1, s2, cst, 1'b0, fp, op, u, 1'b0, p};
  endfunction

  task automatic chk(input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Waits for a taken fetch, sets the next fetch latency, checks each execute packet
  task automatic ep_seq(input logic [31:0] fa, input int n, input logic [63:0] masks,
      input logic [7:0] ill, input logic [3:0] nlat);
    int i;
    i = 0;
    #1;
    while (!(fetch_req === 1'b1 && fetch_vld === 1'b1) && i < 20) begin
      @(negedge mclk);
      #1;
      i++;
    end
    chk(1'b1, fetch_vld);
    chk(fa, fetch_addr);
    // Next request rises with the last packet, so its latency is set now
    lat = nlat;
    repeat (2) @(posedge mclk);
    for (int k = 0; k < n; k++) begin
      @(negedge mclk);
      chk(1'b1, pkt_issue);
      chk(masks[8*k +: 8], unit_valid);
      chk(k == n - 1, fetch_req);
      chk(1'b0, route_err);
      if (k > 0) chk(ill[k-1], illegal_err);
    end
  endtask

  task automatic rd(input logic side, input logic [3:0] idx, input logic [31:0] exp);
    @(negedge mclk);
    dbg_side = side;
    dbg_idx = idx;
    @(negedge mclk);
    chk(exp, dbg_data);
  endtask

  task automatic t_reset();
    @(negedge mclk);
    chk(1'b1, fetch_req);
    chk(32'h0000_0000, fetch_addr);
    chk(8'h00, unit_valid);
    chk(1'b0, pkt_issue);
    $display("test reset done");
  endtask

  task automatic t_split();
    ep_seq(32'h0000_0000, 3, 64'h0000_0000_0031_0133, 8'h00, 4'h3);
    @(negedge mclk);
    chk(1'b1, fetch_req);
    $display("test split done");
  endtask

  task automatic t_full();
    ep_seq(32'h0000_0020, 1, 64'h0000_0000_0000_00FF, 8'h00, 4'h1);
    chk(vfd_pmem_inst.mem[1][2], unit_instr[2]);
    @(negedge mclk);
    chk({2'h3, 32'h0000_0004, 8'hF0}, {mem_out[0].req, mem_out[0].we,
      mem_out[0].addr, mem_out[0].be});
    chk(32'h0000_0005, mem_out[0].wdata[63:32]);
    chk({2'h3, 32'h0000_0003, 8'h08}, {mem_out[1].req, mem_out[1].we,
      mem_out[1].addr, mem_out[1].be});
    chk(8'h09, mem_out[1].wdata[31:24]);
    $display("test full packet done");
  endtask

  task automatic t_eight();
    ep_seq(32'h0000_0040, 8, 64'h0108_0120_0101_0102, 8'h01, 4'h0);
    $display("test eight packets done");
  endtask

  task automatic t_regs();
    rd(1'b0, 4'h1, 32'h0000_0005);
    rd(1'b0, 4'h2, 32'h0000_0007);
    rd(1'b0, 4'h3, 32'h0000_0000);
    rd(1'b0, 4'h6, 32'h0000_0004);
    rd(1'b0, 4'h9, 32'h0000_0023);
    rd(1'b1, 4'h2, 32'hFFFF_FFFF);
    rd(1'b1, 4'h4, 32'h0000_0009);
    rd(1'b1, 4'h8, 32'hFFFF_FFFD);
    rd(1'b1, 4'hA, 32'h3333_4444);
    rd(1'b1, 4'hB, 32'h1111_2222);
    $display("test registers done");
  endtask

  initial begin
    arst_n = 1'b0;
    lat = 4'h0;
    dbg_side = 1'b0;
    dbg_idx = 4'h0;
    mem_rdata = {4{64'h1111_2222_3333_4444}};
    mismatches = 0;
    compares = 0;
    // Packet 0: three execute packets, middle one condition false
    vfd_pmem_inst.mem[0] = {ins(3'h0, 1'b0, 4'h6, 4'h0, 4'h0, 5'h04, 1'b0, 4'h5, 3'h0, 1'b0),
      ins(3'h0, 1'b0, 4'h5, 4'h0, 4'h0, 5'h02, 1'b0, 4'h5, 3'h5, 1'b1),
      ins(3'h1, 1'b1, 4'h4, 4'h0, 4'h0, 5'h09, 1'b0, 4'h5, 3'h4, 1'b1),
      ins(3'h1, 1'b0, 4'h3, 4'h0, 4'h0, 5'h09, 1'b0, 4'h5, 3'h0, 1'b0),
      ins(3'h0, 1'b0, 4'h2, 4'h0, 4'h0, 5'h1F, 1'b0, 4'h5, 3'h5, 1'b0),
      ins(3'h0, 1'b0, 4'h1, 4'h0, 4'h0, 5'h03, 1'b0, 4'h5, 3'h4, 1'b1),
      ins(3'h0, 1'b0, 4'h2, 4'h0, 4'h0, 5'h07, 1'b0, 4'h5, 3'h1, 1'b1),
      ins(3'h0, 1'b0, 4'h1, 4'h0, 4'h0, 5'h05, 1'b0, 4'h5, 3'h0, 1'b1)};
    // Packet 1: all eight units in one execute packet
    vfd_pmem_inst.mem[1] = {ins(3'h0, 1'b0, 4'h4, 4'h0, 4'h0, 5'h03, 1'b0, 4'h8, 3'h7, 1'b0),
      ins(3'h0, 1'b0, 4'h8, 4'h1, 4'h2, 5'h00, 1'b0, 4'h0, 3'h6, 1'b1),
      ins(3'h0, 1'b0, 4'h7, 4'h0, 4'h0, 5'h04, 1'b0, 4'h5, 3'h5, 1'b1),
      ins(3'h0, 1'b0, 4'h6, 4'h0, 4'h0, 5'h03, 1'b0, 4'h5, 3'h4, 1'b1),
      ins(3'h0, 1'b0, 4'h1, 4'h0, 4'h0, 5'h01, 1'b0, 4'hC, 3'h3, 1'b1),
      ins(3'h0, 1'b0, 4'h9, 4'h1, 4'h2, 5'h00, 1'b0, 4'h0, 3'h2, 1'b1),
      ins(3'h0, 1'b0, 4'h8, 4'h0, 4'h0, 5'h02, 1'b0, 4'h5, 3'h1, 1'b1),
      ins(3'h0, 1'b0, 4'h7, 4'h0, 4'h0, 5'h01, 1'b0, 4'h5, 3'h0, 1'b1)};
    // Packet 2: float on shift-branch unit, rest never-true fillers except the double load in slot 4
    for (int j = 1; j < 8; j++) begin
      vfd_pmem_inst.mem[2][j] = ins(3'h7, 1'b0, 4'hF, 4'h0, 4'h0, 5'h01, 1'b0, 4'h5,
        3'h0, 1'b0);
    end
    vfd_pmem_inst.mem[2][0] = ins(3'h0, 1'b0, 4'hC, 4'h0, 4'h0, 5'h00, 1'b1, 4'h0, 3'h1,
      1'b0);
    // Double load on side B into the pair 10 and 11
    vfd_pmem_inst.mem[2][4] = ins(3'h0, 1'b0, 4'hA, 4'h0, 4'h0, 5'h01, 1'b0, 4'hA, 3'h5,
      1'b0);
    // Store whose condition never holds
    vfd_pmem_inst.mem[2][6] = ins(3'h7, 1'b0, 4'h1, 4'h0, 4'h0, 5'h01, 1'b0, 4'hC, 3'h3,
      1'b0);
    vfd_pmem_inst.mem[3] = '0;
    t_reset();
    @(negedge mclk);
    arst_n <= 1'b1;
    t_split();
    t_full();
    t_eight();
    t_regs();
    report_and_stop();
  end

  initial begin
    #5000;
    mismatches++;
    report_and_stop();
  end
endmodule
`default_nettype wire
